// ===== rtl/uotg_bdt_vbus_ctrl.sv
// Top: registers, pull resistor control, boost sequencing and descriptor selection
`timescale 1ns/100ps
`default_nettype none
module uotg_bdt_vbus_ctrl
(
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata,
	// Comparators on the generated bus voltage
	input wire logic vbusOverVoltage,
	input wire logic vbusOverCurrent,
	input wire logic vbusValid,
	// Transaction engine side
	input wire logic txnStart,
	input wire logic [3:0] txnPid,
	input wire logic [3:0] txnEndpoint,
	input wire logic txnOdd,
	input wire logic [15:0] descStatusIn,
	input wire logic txnDone,
	input wire logic [9:0] txnActualCount,
	// Pin control
	output logic dplusPullupOn,
	output logic dplusPulldownOn,
	output logic dminusPulldownOn,
	output logic boostPwmOut,
	output logic vbusGenOn,
	output logic vbusTargetHigh,
	// Descriptor access
	output logic [15:0] descStatusAddr,
	output logic [15:0] descBufAddrAddr,
	output logic txnIsTx,
	output logic txnOwned,
	output logic [3:0] txnRemoteEndpoint,
	output logic [15:0] descStatusOut,
	output logic descStatusWrite
);
	// Reset synchroniser
	logic rstMeta_q;
	logic rstN_q;
	// Software registers
	logic [15:0] mainControl_q;
	logic [15:0] otgControl_q;
	logic [15:0] powerControl_q;
	logic [15:0] periodDuty_q;
	logic [15:0] pwmControl_q;
	logic [7:0] tablePointer_q;
	logic [1:0] config_q;
	logic [15:0] ep0Control_q;
	logic [15:0] token_q;
	logic [15:0] transferStatus_q;
	// Captured status word of the active descriptor
	logic [15:0] heldStatus_q;
	// Combinational helpers
	logic hostMode;
	logic overrideOn;
	logic isTxNow;
	logic [3:0] mapEndpoint;
	logic [15:0] statusAddrNow;
	logic [15:0] bufAddrNow;
	logic pwmNow;
	logic pwmRunning;
	logic [15:0] readMux;

	// Reset release through two flops; assert is asynchronous
	// Synchronous release lets every flop leave reset on the same edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rstMeta_q <= 1'b0;
			rstN_q <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstN_q <= rstMeta_q;
		end
	end

	// Role and override decode shared by pulls and descriptor logic
	// Host role comes straight from the control bit; no negotiation here
	assign hostMode = mainControl_q[uotg_pkg::HOST_ENABLE_BIT];
	assign overrideOn = otgControl_q[uotg_pkg::OTG_OVERRIDE_ENABLE_BIT];

	// Control register writes
	always_ff @(posedge clk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			mainControl_q <= uotg_pkg::REG_RESET;
			otgControl_q <= uotg_pkg::REG_RESET;
			powerControl_q <= uotg_pkg::REG_RESET;
			periodDuty_q <= uotg_pkg::REG_RESET;
			pwmControl_q <= uotg_pkg::REG_RESET;
			tablePointer_q <= 8'h00;
			config_q <= 2'h0;
			ep0Control_q <= uotg_pkg::REG_RESET;
			token_q <= uotg_pkg::REG_RESET;
		end
		else if (regWrite)
		begin
			unique case (regAddr)
				uotg_pkg::MAIN_CONTROL_REG_OFS:
					mainControl_q <= regWdata;
				uotg_pkg::OTG_CONTROL_REG_OFS:
					otgControl_q <= regWdata;
				uotg_pkg::POWER_CONTROL_REG_OFS:
					powerControl_q <= regWdata;
				uotg_pkg::BOOST_PERIOD_DUTY_REG_OFS:
					periodDuty_q <= regWdata;
				uotg_pkg::BOOST_PWM_CONTROL_REG_OFS:
					pwmControl_q <= regWdata;
				uotg_pkg::DESCRIPTOR_TABLE_POINTER_OFS:
					tablePointer_q <= regWdata[7:0];
				uotg_pkg::CONFIG_REG_OFS:
					config_q <= regWdata[1:0];
				uotg_pkg::ENDPOINT0_CONTROL_REG_OFS:
					ep0Control_q <= regWdata;
				uotg_pkg::TOKEN_REG_OFS:
					token_q <= regWdata;
				default:
					; // Read-only or unmapped: ignored
			endcase
		end
	end

	// Pull resistors; override bits take over when OTG control is on
	always_ff @(posedge clk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			dplusPullupOn <= 1'b0;
			dplusPulldownOn <= 1'b0;
			dminusPulldownOn <= 1'b0;
		end
		else if (overrideOn)
		begin
			dplusPullupOn <= otgControl_q[uotg_pkg::DPLUS_PULLUP_CTRL_BIT];
			dplusPulldownOn <= otgControl_q[uotg_pkg::DPLUS_PULLDOWN_CTRL_BIT];
			dminusPulldownOn <= otgControl_q[uotg_pkg::DMINUS_PULLDOWN_CTRL_BIT];
		end
		else
		begin
			// Host pull-downs and device pull-up never fight: host wins
			dplusPullupOn <= mainControl_q[uotg_pkg::MODULE_ENABLE_BIT] && !hostMode;
			dplusPulldownOn <= hostMode;
			dminusPulldownOn <= hostMode;
		end
	end

	// Boost generator instance
	// Comparator faults act inside the generator so the idle level is kept
	uotg_boost_pwm uBoost
	(
		.clk(clk),
		.rstN(rstN_q),
		.period(periodDuty_q[uotg_pkg::PERIOD_LSB +: 8]),
		.duty(periodDuty_q[uotg_pkg::DUTY_LSB +: 8]),
		.counterEnable(pwmControl_q[uotg_pkg::BOOST_COUNTER_ENABLE_BIT]),
		.pwmEnable(pwmControl_q[uotg_pkg::BOOST_PWM_ENABLE_BIT]),
		.polarity(pwmControl_q[uotg_pkg::BOOST_PWM_POLARITY_BIT]),
		.genEnable(otgControl_q[uotg_pkg::VBUS_GEN_ENABLE_BIT]),
		.overVoltage(vbusOverVoltage),
		.overCurrent(vbusOverCurrent),
		.pwmOut(pwmNow),
		.running(pwmRunning)
	);

	// VBUS generation outputs; vbusGenOn is blocked while discharging or unpowered as a safety net, the boost PWM is not
	always_ff @(posedge clk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			boostPwmOut <= 1'b0;
			vbusGenOn <= 1'b0;
			vbusTargetHigh <= 1'b0;
		end
		else
		begin
			boostPwmOut <= pwmNow;
			vbusGenOn <= otgControl_q[uotg_pkg::VBUS_GEN_ENABLE_BIT]
				&& powerControl_q[uotg_pkg::MODULE_POWER_BIT]
				&& !otgControl_q[uotg_pkg::VBUS_DISCHARGE_BIT];
			vbusTargetHigh <= otgControl_q[uotg_pkg::VBUS_TARGET_SELECT_BIT];
		end
	end

	// Direction by role: device receives OUT/SETUP, host receives IN
	// Unknown PID codes fall back to receive in both roles
	always_comb
	begin
		if (hostMode)
			isTxNow = (txnPid == uotg_pkg::PID_OUT) || (txnPid == uotg_pkg::PID_SETUP);
		else
			isTxNow = (txnPid == uotg_pkg::PID_IN);
	end

	// Host mode always maps to endpoint 0 descriptors
	assign mapEndpoint = hostMode ? 4'h0 : txnEndpoint;

	// Descriptor address calculator
	uotg_desc_index uIndex
	(
		.endpoint(mapEndpoint),
		.isTx(isTxNow),
		.oddBuf(txnOdd),
		.pingPong(config_q),
		.tablePointer(tablePointer_q),
		.descIndex(),
		.statusAddr(statusAddrNow),
		.bufferAddrAddr(bufAddrNow)
	);

	// Latch the descriptor selection at transaction start
	// The status word is valid only beside the start pulse, so it is held here
	always_ff @(posedge clk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			descStatusAddr <= 16'h0000;
			descBufAddrAddr <= 16'h0000;
			txnIsTx <= 1'b0;
			txnOwned <= 1'b0;
			txnRemoteEndpoint <= 4'h0;
			heldStatus_q <= 16'h0000;
		end
		else if (txnStart)
		begin
			descStatusAddr <= statusAddrNow;
			descBufAddrAddr <= bufAddrNow;
			txnIsTx <= isTxNow;
			// Skipped unless the module owns it
			txnOwned <= descStatusIn[uotg_pkg::OWNERSHIP_FLAG_BIT];
			// Host addresses the endpoint held in the token register
			txnRemoteEndpoint <= hostMode ? token_q[uotg_pkg::TOKEN_EP_LSB +: 4] : txnEndpoint;
			heldStatus_q <= descStatusIn;
		end
	end

	// Completion write-back: actual count, PID, ownership handed back
	// Output word is refreshed every cycle; only the strobe qualifies it
	always_ff @(posedge clk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			descStatusOut <= 16'h0000;
			descStatusWrite <= 1'b0;
		end
		else
		begin
			descStatusWrite <= txnDone && txnOwned;
			descStatusOut <= {1'b0, heldStatus_q[14], txnPid, txnActualCount};
		end
	end

	// Transfer status capture on completion
	// Unowned descriptors leave the last status in place
	always_ff @(posedge clk or negedge rstN_q)
	begin
		if (!rstN_q)
			transferStatus_q <= uotg_pkg::REG_RESET;
		else if (txnDone && txnOwned)
		begin
			transferStatus_q <= 16'h0000;
			transferStatus_q[uotg_pkg::REPORTED_ENDPOINT_FIELD_LSB +: 4] <= txnRemoteEndpoint;
			transferStatus_q[uotg_pkg::STATUS_DIR_BIT] <= txnIsTx;
		end
	end

	// Read multiplexer; unmapped reads zero
	// Line status bits are live levels, sampled with the strobe
	always_comb
	begin
		readMux = 16'h0000;
		unique case (regAddr)
			uotg_pkg::MAIN_CONTROL_REG_OFS:
				readMux = mainControl_q;
			uotg_pkg::OTG_CONTROL_REG_OFS:
				readMux = otgControl_q;
			uotg_pkg::POWER_CONTROL_REG_OFS:
				readMux = powerControl_q;
			uotg_pkg::BOOST_PERIOD_DUTY_REG_OFS:
				readMux = periodDuty_q;
			uotg_pkg::BOOST_PWM_CONTROL_REG_OFS:
				readMux = pwmControl_q;
			uotg_pkg::DESCRIPTOR_TABLE_POINTER_OFS:
				readMux = {8'h00, tablePointer_q};
			uotg_pkg::CONFIG_REG_OFS:
				readMux = {14'h0000, config_q};
			uotg_pkg::ENDPOINT0_CONTROL_REG_OFS:
				readMux = ep0Control_q;
			uotg_pkg::TRANSFER_STATUS_REG_OFS:
				readMux = transferStatus_q;
			uotg_pkg::TOKEN_REG_OFS:
				readMux = token_q;
			uotg_pkg::LINE_STATUS_OFS:
				readMux = {10'h000, vbusValid, pwmRunning, vbusGenOn, dminusPulldownOn,
					dplusPulldownOn, dplusPullupOn};
			default:
				readMux = 16'h0000;
		endcase
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or negedge rstN_q)
	begin
		if (!rstN_q)
			regRdata <= 16'h0000;
		else if (regRead)
			regRdata <= readMux;
		else
			regRdata <= 16'h0000;
	end
endmodule
`default_nettype wire

// ===== rtl/uotg_pkg.sv
// Package: register offsets, field positions, reset values and types of the USB dual-role config block
package uotg_pkg;
	// Register offsets on the plain register port (word index)
	localparam logic [3:0] MAIN_CONTROL_REG_OFS = 4'h0;
	localparam logic [3:0] OTG_CONTROL_REG_OFS = 4'h1;
	localparam logic [3:0] POWER_CONTROL_REG_OFS = 4'h2;
	localparam logic [3:0] BOOST_PERIOD_DUTY_REG_OFS = 4'h3;
	localparam logic [3:0] BOOST_PWM_CONTROL_REG_OFS = 4'h4;
	localparam logic [3:0] DESCRIPTOR_TABLE_POINTER_OFS = 4'h5;
	localparam logic [3:0] CONFIG_REG_OFS = 4'h6;
	localparam logic [3:0] ENDPOINT0_CONTROL_REG_OFS = 4'h7;
	localparam logic [3:0] TRANSFER_STATUS_REG_OFS = 4'h8;
	localparam logic [3:0] TOKEN_REG_OFS = 4'h9;
	localparam logic [3:0] LINE_STATUS_OFS = 4'hA;
	// Main control fields
	localparam int MODULE_ENABLE_BIT = 0;
	localparam int HOST_ENABLE_BIT = 3;
	// OTG control fields
	localparam int VBUS_DISCHARGE_BIT = 0;
	localparam int VBUS_TARGET_SELECT_BIT = 1;
	localparam int OTG_OVERRIDE_ENABLE_BIT = 2;
	localparam int VBUS_GEN_ENABLE_BIT = 3;
	localparam int DMINUS_PULLDOWN_CTRL_BIT = 4;
	localparam int DPLUS_PULLDOWN_CTRL_BIT = 5;
	localparam int DPLUS_PULLUP_CTRL_BIT = 7;
	// Power control field
	localparam int MODULE_POWER_BIT = 0;
	// Boost PWM fields
	localparam int PERIOD_LSB = 0;
	localparam int DUTY_LSB = 8;
	localparam int BOOST_COUNTER_ENABLE_BIT = 8;
	localparam int BOOST_PWM_POLARITY_BIT = 9;
	localparam int BOOST_PWM_ENABLE_BIT = 15;
	// Config field
	localparam int PINGPONG_LSB = 0;
	// Token register fields
	localparam int TOKEN_EP_LSB = 0;
	localparam int TOKEN_PID_LSB = 4;
	// Transfer status fields
	localparam int STATUS_DIR_BIT = 3;
	localparam int REPORTED_ENDPOINT_FIELD_LSB = 4;
	// Descriptor layout
	localparam int DESC_COUNT = 64;
	localparam int DESC_BYTES = 4;
	localparam logic [15:0] TABLE_ALIGN_BYTES = 16'h0200;
	localparam int BYTE_COUNT_W = 10;
	localparam int OWNERSHIP_FLAG_BIT = 15;
	// Reset values
	localparam logic [15:0] REG_RESET = 16'h0000;
	// Token PID codes (low nibble of the packet identifier)
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hD;
	// Ping-pong buffering modes
	typedef enum logic [1:0]
	{
		PP_NONE = 2'h0,
		PP_EP0_OUT = 2'h1,
		PP_ALL = 2'h2,
		PP_ALL_BUT_EP0 = 2'h3
	} uotg_pingpong_t;
endpackage

// ===== rtl/uotg_boost_pwm.sv
// Boost assist PWM generator with comparator qualified drive
`timescale 1ns/100ps
`default_nettype none
module uotg_boost_pwm
(
	input wire logic clk,
	input wire logic rstN,
	input wire logic [7:0] period,
	input wire logic [7:0] duty,
	input wire logic counterEnable,
	input wire logic pwmEnable,
	input wire logic polarity,
	input wire logic genEnable,
	input wire logic overVoltage,
	input wire logic overCurrent,
	output logic pwmOut,
	output logic running
);
	// Free-running period counter
	logic [7:0] count_q;
	// Raw compare result before gating
	logic highPhase;

	// Counter moves only while enabled, wraps at period
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			count_q <= 8'h00;
		else if (!counterEnable)
			count_q <= 8'h00;
		else if (count_q >= period)
			count_q <= 8'h00;
		else
			count_q <= count_q + 8'h01;
	end

	// Active phase while below duty value
	assign highPhase = (count_q < duty);

	// Output gated by enables and comparators; idle level is the inactive polarity
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			pwmOut <= 1'b0;
		else if (pwmEnable && counterEnable && genEnable && !overVoltage && !overCurrent)
			pwmOut <= highPhase ^ polarity;
		else
			pwmOut <= polarity;
	end

	// Running flag for status reads
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			running <= 1'b0;
		else
			running <= pwmEnable && counterEnable;
	end
endmodule
`default_nettype wire

// ===== rtl/uotg_desc_index.sv
// Descriptor index and byte address calculation from endpoint, direction and ping-pong mode
`timescale 1ns/100ps
`default_nettype none
module uotg_desc_index
(
	input wire logic [3:0] endpoint,
	input wire logic isTx,
	input wire logic oddBuf,
	input wire logic [1:0] pingPong,
	input wire logic [7:0] tablePointer,
	output logic [5:0] descIndex,
	output logic [15:0] statusAddr,
	output logic [15:0] bufferAddrAddr
);
	// Index before truncation to table size
	logic [6:0] idx;
	// Table base on an aligned boundary
	logic [15:0] base;

	// Mapping per buffering mode
	always_comb
	begin
		idx = 7'h00;
		unique case (uotg_pkg::uotg_pingpong_t'(pingPong))
			uotg_pkg::PP_NONE:
				idx = {2'h0, endpoint, isTx};
			uotg_pkg::PP_EP0_OUT:
				if (endpoint == 4'h0 && !isTx)
					idx = {6'h00, oddBuf};
				else
					idx = {2'h0, endpoint, isTx} + 7'h01;
			uotg_pkg::PP_ALL:
				idx = {1'b0, endpoint, isTx, oddBuf};
			uotg_pkg::PP_ALL_BUT_EP0:
				if (endpoint == 4'h0)
					idx = {6'h00, isTx};
				else
					idx = {1'b0, endpoint, isTx, oddBuf} - 7'h02;
		endcase
	end

	assign descIndex = idx[5:0];
	// Pointer bits 7:1 set address bits 15:9; low nine bits forced zero for alignment
	assign base = {tablePointer[7:1], 9'h000};
	assign statusAddr = base + {8'h00, descIndex, 2'h0};
	assign bufferAddrAddr = statusAddr + 16'h0002;
endmodule
`default_nettype wire

// ===== tb/uotg_bdt_vbus_ctrl_properties.sv
// Checker: timing relations on the top ports of the USB dual-role config block
`timescale 1ns/100ps
`default_nettype none
module uotg_bdt_vbus_ctrl_properties
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic txnStart,
	input wire logic [3:0] txnPid,
	input wire logic [3:0] txnEndpoint,
	input wire logic txnDone,
	input wire logic [9:0] txnActualCount,
	input wire logic dplusPullupOn,
	input wire logic dplusPulldownOn,
	input wire logic dminusPulldownOn,
	input wire logic boostPwmOut,
	input wire logic vbusGenOn,
	input wire logic [15:0] descStatusAddr,
	input wire logic [15:0] descBufAddrAddr,
	input wire logic txnIsTx,
	input wire logic txnOwned,
	input wire logic [3:0] txnRemoteEndpoint,
	input wire logic [15:0] descStatusOut
);
	// Shadow copies of the software registers
	logic [15:0] ctl_q, otg_q, pwr_q, pwm_q, ptr_q, cfg_q, tok_q;
	// Cycles since the last write; the PWM path is two flops deep
	logic [1:0] cnt_q;
	// Expected direction and descriptor address for the lines now
	logic expTx;
	logic [3:0] epSel;
	logic [15:0] expAddr;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// Mirror writes to every register the checks read, as the design takes them
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			{ctl_q, otg_q, pwr_q, pwm_q, ptr_q, cfg_q, tok_q} <= '0;
		else if (regWrite)
		begin
			case (regAddr)
				uotg_pkg::MAIN_CONTROL_REG_OFS: ctl_q <= regWdata;
				uotg_pkg::OTG_CONTROL_REG_OFS: otg_q <= regWdata;
				uotg_pkg::POWER_CONTROL_REG_OFS: pwr_q <= regWdata;
				uotg_pkg::BOOST_PWM_CONTROL_REG_OFS: pwm_q <= regWdata;
				uotg_pkg::DESCRIPTOR_TABLE_POINTER_OFS: ptr_q <= regWdata;
				uotg_pkg::CONFIG_REG_OFS: cfg_q <= regWdata;
				uotg_pkg::TOKEN_REG_OFS: tok_q <= regWdata;
				default: ;
			endcase
		end
	end
	// Saturating settle counter, cleared by any write
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cnt_q <= 2'h0;
		else if (regWrite)
			cnt_q <= 2'h0;
		else if (cnt_q != 2'h3)
			cnt_q <= cnt_q + 2'h1;
	end
	// Host role always lands on the endpoint 0 descriptors
	assign expTx = ctl_q[3] ? (txnPid != uotg_pkg::PID_IN) : (txnPid == uotg_pkg::PID_IN);
	assign epSel = ctl_q[3] ? 4'h0 : txnEndpoint;
	assign expAddr = {ptr_q[7:1], 9'h000} + {9'h000, epSel, expTx, 2'h0};

	property p_pullup_plain; $past(!otg_q[2]) |-> dplusPullupOn == $past(ctl_q[0] & !ctl_q[3]); endproperty
	a_pullup_plain: assert property (p_pullup_plain) else $error("pull-up off enable");
	property p_pullup_ovr; $past(otg_q[2]) |-> dplusPullupOn == $past(otg_q[7]); endproperty
	a_pullup_ovr: assert property (p_pullup_ovr) else $error("pull-up off override bit");
	property p_pd_host; $past(!otg_q[2]) |-> {dplusPulldownOn, dminusPulldownOn} == {2{$past(ctl_q[3])}}; endproperty
	a_pd_host: assert property (p_pd_host) else $error("pull-downs off host bit");
	property p_pd_ovr; $past(otg_q[2]) |-> {dplusPulldownOn, dminusPulldownOn} == $past(otg_q[5:4]); endproperty
	a_pd_ovr: assert property (p_pd_ovr) else $error("pull-downs off override bits");
	property p_gen; vbusGenOn == $past(otg_q[3] & pwr_q[0] & !otg_q[0]); endproperty
	a_gen: assert property (p_gen) else $error("generation enable wrong");
	property p_pwm_idle; cnt_q == 2'h3 && !pwm_q[15] |-> boostPwmOut == pwm_q[9]; endproperty
	a_pwm_idle: assert property (p_pwm_idle) else $error("disabled PWM not idle");
	property p_dir; txnStart |=> txnIsTx == $past(expTx); endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	property p_addr; txnStart && cfg_q[1:0] == 2'h0 |=> descStatusAddr == $past(expAddr) && descBufAddrAddr == $past(expAddr) + 16'h0002; endproperty
	a_addr: assert property (p_addr) else $error("descriptor address wrong");
	property p_remote; txnStart && ctl_q[3] |=> txnRemoteEndpoint == $past(tok_q[3:0]); endproperty
	a_remote: assert property (p_remote) else $error("remote endpoint wrong");
	property p_count; txnDone && txnOwned |=> descStatusOut[9:0] == $past(txnActualCount); endproperty
	a_count: assert property (p_count) else $error("byte count not written back");
endmodule
`default_nettype wire

// ===== tb/uotg_txn_partner.sv
// Transaction engine and bus-voltage comparator model facing the config block
`timescale 1ns/100ps
`default_nettype none
module uotg_txn_partner
(
	input wire logic clk,
	output logic txnStart,
	output logic [3:0] txnPid,
	output logic [3:0] txnEndpoint,
	output logic txnOdd,
	output logic [15:0] descStatusIn,
	output logic txnDone,
	output logic [9:0] txnActualCount,
	output logic vbusOverVoltage,
	output logic vbusOverCurrent,
	output logic vbusValid
);
	// Quiet lines at time zero
	initial
	begin
		{txnStart, txnPid, txnEndpoint, txnOdd, descStatusIn, txnDone, txnActualCount} = '0;
		{vbusOverVoltage, vbusOverCurrent, vbusValid} = 3'h0;
	end
	// Comparator levels; a fault must force the boost idle
	task automatic setComp(input logic ov, input logic oc, input logic vv);
		@(posedge clk);
		vbusOverVoltage <= ov;
		vbusOverCurrent <= oc;
		vbusValid <= vv;
	endtask
	// One transfer: start pulse, one idle cycle, completion pulse
	task automatic xfer(input logic [3:0] p, input logic [3:0] e, input logic o, input logic [15:0] s,
		input logic [9:0] n);
		@(posedge clk);
		txnPid <= p;
		txnEndpoint <= e;
		txnOdd <= o;
		descStatusIn <= s;
		txnStart <= 1'b1;
		@(posedge clk);
		txnStart <= 1'b0;
		descStatusIn <= ~s; // Word no longer valid, so never show the old value
		@(posedge clk);
		txnActualCount <= n;
		txnDone <= 1'b1;
		@(posedge clk);
		txnDone <= 1'b0;
		txnActualCount <= ~n;
	endtask
endmodule
`default_nettype wire

// ===== tb/uotg_bdt_vbus_ctrl_bench.sv
// Self-checking bench for the USB dual-role config block
`timescale 1ns/100ps
`default_nettype none
module uotg_bdt_vbus_ctrl_bench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [15:0] regRdata, descStatusIn, descStatusAddr, descBufAddrAddr, descStatusOut, rv;
	logic vbusOverVoltage, vbusOverCurrent, vbusValid, txnStart, txnOdd, txnDone, txnIsTx, txnOwned;
	logic dplusPullupOn, dplusPulldownOn, dminusPulldownOn, boostPwmOut, vbusGenOn, vbusTargetHigh, descStatusWrite;
	logic [3:0] txnPid, txnEndpoint, txnRemoteEndpoint;
	logic [9:0] txnActualCount;
	// Pull table: main control, OTG control, expected {D- pd, D+ pd, pull-up}
	logic [15:0] pm [6] = '{16'h0001, 16'h0009, 16'h0000, 16'h0001, 16'h0008, 16'h0008};
	logic [15:0] po [6] = '{16'h0000, 16'h0000, 16'h0084, 16'h0004, 16'h0024, 16'h0014};
	logic [15:0] pe [6] = '{16'h0001, 16'h0006, 16'h0001, 16'h0000, 16'h0002, 16'h0004};
	logic [3:0] pid [3] = '{uotg_pkg::PID_OUT, uotg_pkg::PID_IN, uotg_pkg::PID_SETUP};
	int errTotal = 0;
	int comparisons = 0;
	uotg_bdt_vbus_ctrl uotg_bdt_vbus_ctrl_i (.*);
	uotg_txn_partner uotg_txn_partner_i (.*);
	// 100 MHz clock
	always #5 clk = ~clk;
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		d = regRdata;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			errTotal++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// High cycles of the boost output over ten cycles, after it settles
	task automatic countHigh(output logic [15:0] n);
		n = 16'h0000;
		repeat (3) @(posedge clk);
		repeat (10)
		begin
			@(posedge clk);
			#1;
			n = n + {15'h0000, boostPwmOut};
		end
	endtask
	// Owned transfer with table base 16'h1200
	task automatic txn(input logic [3:0] p, input logic [3:0] e, input logic o, input logic [5:0] idx, input logic tx);
		uotg_txn_partner_i.xfer(p, e, o, 16'h8000, 10'h155);
		#1;
		chk("direction", {15'h0000, tx}, {15'h0000, txnIsTx});
		chk("status addr", 16'h1200 + {8'h00, idx, 2'h0}, descStatusAddr);
		chk("buffer addr", 16'h1202 + {8'h00, idx, 2'h0}, descBufAddrAddr);
		chk("count", 16'h0155, {6'h00, descStatusOut[9:0]});
		chk("write pulse", 16'h0001, {15'h0000, descStatusWrite});
		chk("owned", 16'h0001, {15'h0000, txnOwned});
	endtask
	task automatic printVerdict;
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 16; i++)
		begin
			rd(i[3:0], rv);
			chk("reset value", 16'h0000, rv);
		end
		$display("test reset done");
		uotg_txn_partner_i.setComp(1'b0, 1'b0, 1'b1);
		for (int i = 0; i < 6; i++)
		begin
			wr(uotg_pkg::MAIN_CONTROL_REG_OFS, pm[i]);
			wr(uotg_pkg::OTG_CONTROL_REG_OFS, po[i]);
			@(posedge clk);
			#1;
			chk("pulls", pe[i], {13'h0000, dminusPulldownOn, dplusPulldownOn, dplusPullupOn});
		end
		wr(uotg_pkg::OTG_CONTROL_REG_OFS, 16'h0000);
		$display("test pulls done");
		wr(uotg_pkg::POWER_CONTROL_REG_OFS, 16'h0001);
		rd(uotg_pkg::POWER_CONTROL_REG_OFS, rv);
		chk("power bit", 16'h0001, rv);
		rd(uotg_pkg::OTG_CONTROL_REG_OFS, rv);
		chk("discharge bit", 16'h0000, rv);
		wr(uotg_pkg::BOOST_PERIOD_DUTY_REG_OFS, 16'h0204);
		wr(uotg_pkg::BOOST_PWM_CONTROL_REG_OFS, 16'h0200);
		countHigh(rv);
		chk("idle inverted", 16'h000A, rv);
		wr(uotg_pkg::OTG_CONTROL_REG_OFS, 16'h0002);
		@(posedge clk);
		#1;
		chk("target", 16'h0001, {15'h0000, vbusTargetHigh});
		wr(uotg_pkg::BOOST_PWM_CONTROL_REG_OFS, 16'h0300);
		wr(uotg_pkg::BOOST_PWM_CONTROL_REG_OFS, 16'h8300);
		wr(uotg_pkg::OTG_CONTROL_REG_OFS, 16'h000A);
		countHigh(rv);
		chk("pwm high count", 16'h0006, rv);
		chk("gen on", 16'h0001, {15'h0000, vbusGenOn});
		uotg_txn_partner_i.setComp(1'b1, 1'b0, 1'b1);
		countHigh(rv);
		chk("fault idle", 16'h000A, rv);
		uotg_txn_partner_i.setComp(1'b0, 1'b0, 1'b1);
		wr(uotg_pkg::OTG_CONTROL_REG_OFS, 16'h000B);
		@(posedge clk);
		#1;
		chk("gen with discharge", 16'h0000, {15'h0000, vbusGenOn});
		$display("test boost done");
		// Back to the device role for the device-side index cases
		wr(uotg_pkg::MAIN_CONTROL_REG_OFS, 16'h0001);
		wr(uotg_pkg::DESCRIPTOR_TABLE_POINTER_OFS, 16'h0013);
		for (int i = 0; i < 3; i++)
			txn(pid[i], 4'h5, 1'b0, {1'b0, 4'h5, pid[i] == uotg_pkg::PID_IN}, pid[i] == uotg_pkg::PID_IN);
		wr(uotg_pkg::CONFIG_REG_OFS, 16'h0002);
		txn(uotg_pkg::PID_IN, 4'hF, 1'b1, 6'h3F, 1'b1);
		wr(uotg_pkg::CONFIG_REG_OFS, 16'h0000);
		wr(uotg_pkg::MAIN_CONTROL_REG_OFS, 16'h0008);
		wr(uotg_pkg::TOKEN_REG_OFS, 16'h0097);
		// Engine endpoint differs from the token, so only the token can give 7
		txn(uotg_pkg::PID_IN, 4'h2, 1'b0, 6'h00, 1'b0);
		chk("remote ep", 16'h0007, {12'h000, txnRemoteEndpoint});
		rd(uotg_pkg::TRANSFER_STATUS_REG_OFS, rv);
		chk("status ep", 16'h0070, rv & 16'h00F8);
		txn(uotg_pkg::PID_OUT, 4'h3, 1'b0, 6'h01, 1'b1);
		uotg_txn_partner_i.xfer(uotg_pkg::PID_OUT, 4'h0, 1'b0, 16'h0000, 10'h001);
		#1;
		chk("not owned", 16'h0000, {15'h0000, descStatusWrite});
		chk("owned flag", 16'h0000, {15'h0000, txnOwned});
		$display("test descriptors done");
		printVerdict();
	end
	// Watchdog; the tests need well under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		errTotal++;
		printVerdict();
	end
endmodule
bind uotg_bdt_vbus_ctrl uotg_bdt_vbus_ctrl_properties uotg_bdt_vbus_ctrl_properties_i (.*);
`default_nettype wire
